// file: logic/hfis_fifo.sv
/*
  Flip-flop byte store with a write index, a read index and an occupancy count.
  Assumes one clock, synchronous reset, and that callers never read it empty.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hfis_params.svh"
module hfis_fifo #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic [AW:0] count_o
);
  // ==========================================================================
  // Storage and indices.
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hfis_fifo_st_t;
  hfis_fifo_st_t s_q, s_d;

  // Next state: a write beyond full overwrites the slot at the write index.
  always_comb begin
    s_d = s_q;
    if (clear_i) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end else begin
      if (wr_i) begin
        s_d.mem[s_q.wp] = wdata_i;
        s_d.wp = s_q.wp + 1'b1;
      end
      if (rd_i) begin
        s_d.rp = s_q.rp + 1'b1;
      end
      if (wr_i && !rd_i && s_q.cnt != DEPTH[AW:0]) begin
        s_d.cnt = s_q.cnt + 1'b1;
      end else if (rd_i && !wr_i && s_q.cnt != '0) begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  // Register the state.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.mem[s_q.rp];
  assign count_o = s_q.cnt;
endmodule : hfis_fifo
`default_nettype wire

// file: logic/hfis_params.svh
/*
  Offsets, field positions, reset values and sizes of the frame FIFO, interrupt and status block.
  Assumes it is included by bare name from every file that needs these names.
*/
`ifndef HFIS_PARAMS_SVH
`define HFIS_PARAMS_SVH

// ==========================================================================
// Register offsets (byte address on the plain register port).
`define HFIS_ADR_TXWIN_LAST 8'h1F
`define HFIS_ADR_RXFIFO 8'h20
`define HFIS_ADR_ISTAT 8'h21
`define HFIS_ADR_IMASK 8'h22
`define HFIS_ADR_STAT 8'h23
`define HFIS_ADR_CMD 8'h24
`define HFIS_ADR_EXMODE 8'h25
`define HFIS_ADR_RECEIVE_BYTE_COUNT_LOW 8'h26
`define HFIS_ADR_RECEIVE_BYTE_COUNT_HIGH 8'h27

// ==========================================================================
// Interrupt status bit positions.
`define HFIS_IS_RME 7
`define HFIS_IS_RPF 6
`define HFIS_IS_RFO 5
`define HFIS_IS_XPR 4
`define HFIS_IS_XMR 3
`define HFIS_IS_XDU 2

// ==========================================================================
// Status register bit positions.
`define HFIS_ST_TRANSMIT_DATA_OVERFLOW 7
`define HFIS_ST_XFW 6
`define HFIS_ST_RECEIVER_ACTIVE_FLAG 3
`define HFIS_ST_TRANSMITTER_ACTIVE_FLAG 1

// ==========================================================================
// Command bits.
`define HFIS_CMD_RMC 7
`define HFIS_CMD_RRES 6
`define HFIS_CMD_XTF 3
`define HFIS_CMD_XME 1
`define HFIS_CMD_TRANSMITTER_RESET_CMD 0

// ==========================================================================
// Extended mode bits.
`define HFIS_EX_TRANSMIT_BLOCK_SIZE 7
`define HFIS_EX_RECEIVE_BLOCK_SIZE_HI 6
`define HFIS_EX_RECEIVE_BLOCK_SIZE_LO 5
`define HFIS_EX_XTRANS 0

// ==========================================================================
// Reset values and sizes.
`define HFIS_RST_ISTAT 8'h10
`define HFIS_RST_IMASK 8'hFC
`define HFIS_RST_STAT 8'h40
`define HFIS_POOL_BIG 6'h20
`define HFIS_POOL_SMALL 6'h10
`define HFIS_ABORT_ONES 3'h7

`endif

// file: logic/hfis_pkg.sv
/*
  Types shared by the frame FIFO, interrupt and status block.
  Assumes hfis_params.svh is available for the constants.
*/
`default_nettype none
package hfis_pkg;
  // ========================================================================
  // Transmit line states, Gray coded along idle, data, crc, abort.
  typedef enum logic [1:0] {
    HFIS_TX_IDLE = 2'h0,
    HFIS_TX_DATA = 2'h1,
    HFIS_TX_TAIL = 2'h3,
    HFIS_TX_ABORT = 2'h2
  } hfis_tx_t;
endpackage : hfis_pkg
`default_nettype wire

// file: logic/hfis_top.sv
/*
  Frame FIFO, interrupt and status block of an HDLC controller: transmit pool
  FIFO, receive block FIFO, sticky flags with mask, status bits, byte count.
  Assumes a byte-wide line side that presents received bytes with frame marks
  and takes transmit bytes on request; one 10 MHz clock; synchronous reset.
*/
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "hfis_params.svh"
module hfis_top (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  input wire logic tx_req_i,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output logic tx_crc_o,
  output logic tx_abort_o,
  input wire logic tx_done_i,
  input wire logic collision_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_open_i,
  input wire logic rx_end_i,
  input wire logic rx_abort_i
);
  // ==========================================================================
  // All state of the block.
  typedef struct packed {
    logic [7:0] istat;      // Sticky interrupt flags, pending regardless of mask.
    logic [7:0] imask;      // One hides a flag.
    logic [7:0] exmode;     // Block sizes and mode.
    logic transmit_block_size;             // Transmit block size in force, latched on commands.
    logic [1:0] receive_block_size;       // Receive block size in force.
    logic transmit_data_overflow;             // Pool overfilled.
    logic receiver_active_flag;             // Receiver active.
    logic transmitter_active_flag;             // Transmitter active.
    logic [5:0] pool_wr;    // Bytes written into the current pool.
    logic last_pool;        // Message end given: frame is complete in FIFO.
    logic both_cmd;         // Both commands given together.
    logic [7:0] sent;       // Bytes sent in this frame, saturating.
    hfis_pkg::hfis_tx_t txs;
    logic [2:0] ones;       // Abort ones still to send.
    logic rx_drop;          // Current receive frame is discarded.
    logic rx_busy;          // Receive FIFO holds unconfirmed data.
    logic [5:0] rx_blk;     // Bytes in current receive block.
    logic [11:0] rbc;       // Received byte count.
    logic [7:0] rdata;
    logic irq;
    logic [7:0] txb;
    logic txv;
    logic txc;
    logic txa;
  } hfis_st_t;
  hfis_st_t s_q, s_d;

  logic [5:0] tx_cnt;
  logic [7:0] tx_head;
  logic [5:0] rx_cnt;
  logic [7:0] rx_head;
  logic tx_push, tx_pop, tx_clr, rx_push, rx_pop, rx_clr;

  // Pool size in bytes from the block size bit.
  function automatic logic [5:0] pool_sz(input logic transmit_block_size);
    pool_sz = transmit_block_size ? `HFIS_POOL_SMALL : `HFIS_POOL_BIG;
  endfunction : pool_sz

  // Receive block size: 32, 16, 8 or 4 bytes.
  function automatic logic [5:0] rblk_sz(input logic [1:0] receive_block_size);
    rblk_sz = 6'h20 >> receive_block_size;
  endfunction : rblk_sz

  wire logic wr_win = wr_i && (addr_i <= `HFIS_ADR_TXWIN_LAST);
  wire logic wr_cmd = wr_i && (addr_i == `HFIS_ADR_CMD);
  wire logic cmd_xtf = wr_cmd && wdata_i[`HFIS_CMD_XTF];
  wire logic cmd_xme = wr_cmd && wdata_i[`HFIS_CMD_XME];
  wire logic cmd_transmitter_reset_cmd = wr_cmd && wdata_i[`HFIS_CMD_TRANSMITTER_RESET_CMD];
  wire logic cmd_rmc = wr_cmd && wdata_i[`HFIS_CMD_RMC];
  wire logic cmd_rres = wr_cmd && wdata_i[`HFIS_CMD_RRES];

  // ==========================================================================
  // FIFO control strobes.
  assign tx_push = wr_win && !cmd_transmitter_reset_cmd;
  assign tx_clr = cmd_transmitter_reset_cmd;
  assign tx_pop = (s_q.txs == hfis_pkg::HFIS_TX_DATA) && tx_req_i && (tx_cnt != '0);
  assign rx_push = rx_valid_i && !s_q.rx_drop && !s_q.rx_busy && (rx_cnt != 6'h20);
  assign rx_pop = rd_i && (addr_i == `HFIS_ADR_RXFIFO) && (rx_cnt != '0);
  assign rx_clr = cmd_rmc || cmd_rres;

  hfis_fifo #(.DEPTH(32), .AW(5)) u_txf (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .clear_i(tx_clr),
    .wr_i(tx_push), .wdata_i(wdata_i), .rd_i(tx_pop), .rdata_o(tx_head), .count_o(tx_cnt)
  );
  hfis_fifo #(.DEPTH(32), .AW(5)) u_rxf (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .clear_i(rx_clr),
    .wr_i(rx_push), .wdata_i(rx_byte_i), .rd_i(rx_pop), .rdata_o(rx_head), .count_o(rx_cnt)
  );

  // ==========================================================================
  // Next-state logic. Hardware sets of a flag win over a software clear.
  always_comb begin
    logic [7:0] set;
    logic [7:0] vis;
    logic [7:0] stat;
    set = '0;
    vis = '0;
    stat = '0;
    s_d = s_q;
    s_d.txv = 1'b0;
    s_d.txc = 1'b0;
    s_d.txa = 1'b0;
    // Host writes to settings.
    if (wr_i && addr_i == `HFIS_ADR_IMASK) begin
      s_d.imask = wdata_i;
    end
    if (wr_i && addr_i == `HFIS_ADR_EXMODE) begin
      s_d.exmode = wdata_i;
    end
    // Pool fill counting; a byte beyond the pool sets the overflow flag.
    if (tx_push) begin
      if (s_q.pool_wr == pool_sz(s_q.transmit_block_size)) begin
        s_d.transmit_data_overflow = 1'b1;
      end else begin
        s_d.pool_wr = s_q.pool_wr + 6'h01;
      end
    end
    // Transmit commands; the transmit block size takes effect here.
    if (cmd_transmitter_reset_cmd) begin
      s_d.txs = hfis_pkg::HFIS_TX_IDLE;
      s_d.transmitter_active_flag = 1'b0;
      s_d.transmit_data_overflow = 1'b0;
      s_d.pool_wr = '0;
      s_d.sent = '0;
      s_d.last_pool = 1'b0;
      s_d.transmit_block_size = s_q.exmode[`HFIS_EX_TRANSMIT_BLOCK_SIZE];
      set[`HFIS_IS_XPR] = 1'b1;
    end else if (cmd_xtf || cmd_xme) begin
      s_d.transmit_block_size = s_q.exmode[`HFIS_EX_TRANSMIT_BLOCK_SIZE];
      s_d.pool_wr = '0;
      s_d.transmit_data_overflow = 1'b0;
      s_d.last_pool = cmd_xme;
      s_d.both_cmd = cmd_xtf && cmd_xme;
      if (cmd_xtf) begin
        s_d.transmitter_active_flag = 1'b1;
      end
      s_d.txs = hfis_pkg::HFIS_TX_DATA;
    end
    // Transmit line side.
    case (s_q.txs)
      hfis_pkg::HFIS_TX_IDLE: begin
      end
      hfis_pkg::HFIS_TX_DATA: begin
        if (tx_pop) begin
          s_d.txb = tx_head;
          s_d.txv = 1'b1;
          if (s_q.sent != 8'hFF) begin
            s_d.sent = s_q.sent + 8'h01;
          end
          // Pool freed while frame incomplete.
          if (tx_cnt == 6'h01 && !s_q.last_pool && !s_q.both_cmd) begin
            set[`HFIS_IS_XPR] = 1'b1;
          end
        end else if (tx_req_i && tx_cnt == '0) begin
          if (s_q.last_pool) begin
            s_d.txs = hfis_pkg::HFIS_TX_TAIL;
          end else if (s_q.sent != '0) begin
            s_d.txs = hfis_pkg::HFIS_TX_ABORT;
            s_d.ones = `HFIS_ABORT_ONES;
            set[`HFIS_IS_XDU] = 1'b1;
          end
        end
      end
      hfis_pkg::HFIS_TX_TAIL: begin
        // Check sum and closing flag unless in extended transparent mode.
        s_d.txc = !s_q.exmode[`HFIS_EX_XTRANS];
        if (tx_done_i) begin
          s_d.txs = hfis_pkg::HFIS_TX_IDLE;
          s_d.transmitter_active_flag = 1'b0;
          s_d.sent = '0;
          set[`HFIS_IS_XPR] = 1'b1;
        end
      end
      hfis_pkg::HFIS_TX_ABORT: begin
        s_d.txa = 1'b1;
        if (tx_req_i) begin
          s_d.ones = s_q.ones - 3'h1;
          if (s_q.ones == 3'h1) begin
            s_d.txs = hfis_pkg::HFIS_TX_IDLE;
            s_d.transmitter_active_flag = 1'b0;
            s_d.sent = '0;
          end
        end
      end
      default: begin
        s_d.txs = hfis_pkg::HFIS_TX_IDLE;
      end
    endcase
    // Collision after the first pool asks for a repeat.
    if (collision_i && s_q.txs != hfis_pkg::HFIS_TX_IDLE &&
        s_q.sent >= {2'h0, pool_sz(s_q.transmit_block_size)}) begin
      set[`HFIS_IS_XMR] = 1'b1;
      s_d.txs = hfis_pkg::HFIS_TX_IDLE;
      s_d.transmitter_active_flag = 1'b0;
      s_d.sent = '0;
    end
    // Receive side.
    if (rx_clr) begin
      s_d.rx_busy = 1'b0;
      s_d.rx_blk = '0;
      s_d.receive_block_size = s_q.exmode[`HFIS_EX_RECEIVE_BLOCK_SIZE_HI:`HFIS_EX_RECEIVE_BLOCK_SIZE_LO];
    end
    if (rx_open_i) begin
      s_d.receiver_active_flag = 1'b1;
      s_d.rx_drop = s_q.rx_busy;
      s_d.rbc = '0;
    end
    if (rx_abort_i) begin
      s_d.receiver_active_flag = 1'b0;
    end
    if (rx_valid_i && (s_q.rx_busy || s_q.rx_drop)) begin
      if (!s_q.rx_drop) begin
        set[`HFIS_IS_RFO] = 1'b1;
      end
      s_d.rx_drop = 1'b1;
    end else if (rx_push) begin
      s_d.rbc = s_q.rbc + 12'h001;
      s_d.rx_blk = s_q.rx_blk + 6'h01;
      if (s_q.rx_blk + 6'h01 == rblk_sz(s_q.receive_block_size) && !rx_end_i) begin
        set[`HFIS_IS_RPF] = 1'b1;
        s_d.rx_busy = 1'b1;
      end
    end
    if (rx_end_i) begin
      if (!s_q.rx_drop && !(rx_valid_i && s_q.rx_busy)) begin
        set[`HFIS_IS_RME] = 1'b1;
        s_d.rx_busy = 1'b1;
      end
      s_d.rx_drop = 1'b0;
    end
    // Flags clear on read of their visible bits; sets win.
    vis = s_q.istat & ~s_q.imask;
    if (rd_i && addr_i == `HFIS_ADR_ISTAT) begin
      s_d.istat = (s_q.istat & s_q.imask) | set;
    end else begin
      s_d.istat = s_q.istat | set;
    end
    s_d.irq = |((s_d.istat) & ~s_d.imask);
    // Status view.
    stat[`HFIS_ST_TRANSMIT_DATA_OVERFLOW] = s_q.transmit_data_overflow;
    stat[`HFIS_ST_XFW] = (tx_cnt <= 6'h20 - pool_sz(s_q.transmit_block_size)) && (s_q.pool_wr != pool_sz(s_q.transmit_block_size));
    stat[`HFIS_ST_RECEIVER_ACTIVE_FLAG] = s_q.receiver_active_flag;
    stat[`HFIS_ST_TRANSMITTER_ACTIVE_FLAG] = s_q.transmitter_active_flag;
    // Read data, one cycle after the strobe.
    s_d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        `HFIS_ADR_RXFIFO: s_d.rdata = rx_head;
        `HFIS_ADR_ISTAT: s_d.rdata = vis;
        `HFIS_ADR_IMASK: s_d.rdata = s_q.imask;
        `HFIS_ADR_STAT: s_d.rdata = stat;
        `HFIS_ADR_EXMODE: s_d.rdata = s_q.exmode;
        `HFIS_ADR_RECEIVE_BYTE_COUNT_LOW: s_d.rdata = s_q.rbc[7:0];
        `HFIS_ADR_RECEIVE_BYTE_COUNT_HIGH: s_d.rdata = {4'h0, s_q.rbc[11:8]};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // Register all state; istat and imask reset values come from the header, the rest resets to zero.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.istat <= `HFIS_RST_ISTAT;
      s_q.imask <= `HFIS_RST_IMASK;
      s_q.txs <= hfis_pkg::HFIS_TX_IDLE;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign irq_o = s_q.irq;
  assign tx_byte_o = s_q.txb;
  assign tx_valid_o = s_q.txv;
  assign tx_crc_o = s_q.txc;
  assign tx_abort_o = s_q.txa;

  // ==========================================================================
  // Checks.
  chk_irq_follows_flags: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i |=> irq_o == |($past(s_d.istat) & ~$past(s_d.imask))) else $error("irq mismatch");
  chk_transmit_block_size_pool_size: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && (cmd_xtf || cmd_xme || cmd_transmitter_reset_cmd) |=> s_q.transmit_block_size == $past(s_q.exmode[`HFIS_EX_TRANSMIT_BLOCK_SIZE]))
    else $error("pool size not latched");
  chk_masked_kept: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && s_q.istat[`HFIS_IS_XPR] && s_q.imask[`HFIS_IS_XPR] |=> s_q.istat[`HFIS_IS_XPR])
    else $error("masked flag lost");
  chk_transmitter_reset_cmd_empties: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && cmd_transmitter_reset_cmd |=> tx_cnt == '0 && !s_q.transmitter_active_flag) else $error("transmitter_reset_cmd did not clear");
  chk_xdu_abort: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && s_q.txs == hfis_pkg::HFIS_TX_DATA && s_d.txs == hfis_pkg::HFIS_TX_ABORT
    |=> s_q.istat[`HFIS_IS_XDU] && s_q.ones == 3'h7) else $error("underrun not flagged");
  chk_xtf_active: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && cmd_xtf && !cmd_transmitter_reset_cmd |=> s_q.transmitter_active_flag) else $error("transmitter_active_flag not set");
  chk_receiver_active_flag_abort: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && rx_abort_i |=> !s_q.receiver_active_flag) else $error("receiver_active_flag not cleared");
  chk_rfo_drop: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && rx_valid_i && s_q.rx_busy && !s_q.rx_drop |=> s_q.istat[`HFIS_IS_RFO] && !$past(rx_push))
    else $error("overflow not flagged");
  chk_rme_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && rx_end_i && !s_q.rx_drop && !s_q.rx_busy |=> s_q.istat[`HFIS_IS_RME])
    else $error("message end missed");
  chk_tx_fill: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clk_en_i && tx_push && !tx_pop && tx_cnt < 6'h20 |=> tx_cnt == $past(tx_cnt) + 6'h01)
    else $error("fifo did not advance");
endmodule : hfis_top
`default_nettype wire

// file: verif/hfis_line_model.sv
/*
  Line-side partner: requests transmit bytes, closes the frame tail, sends receive frames.
  Assumes the same clock and synchronous reset as the block; the bench starts each frame.
*/
`timescale 1ns/1ps
`default_nettype none
module hfis_line_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [5:0] len_i,
  input wire logic tx_crc_i,
  output logic tx_req_o,
  output logic tx_done_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rx_open_o,
  output logic rx_end_o,
  output logic rx_abort_o,
  output logic busy_o
);
  // ==========================================================================
  // State of the partner.
  logic [1:0] div_q; // Request pacing, one request every fourth cycle.
  logic [1:0] crc_q; // Cycles of tail seen so far.
  logic [6:0] step_q; // Receive step: odd steps carry a byte.
  logic [5:0] len_q; // Length of the frame being sent.
  logic abt_q; // Frame ends in an abort instead of a closing flag.

  // ==========================================================================
  // One process keeps both directions; requests run on so an abort can drain.
  always @(posedge sys_clk_i) begin
    rx_valid_o <= 1'b0;
    rx_open_o <= 1'b0;
    rx_end_o <= 1'b0;
    rx_abort_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o; // A line without a byte shows the cycle before it inverted.
    if (reset_i) begin
      {div_q, crc_q, step_q, len_q, abt_q, busy_o, tx_req_o, tx_done_o, rx_byte_o} <= '0;
    end else begin
      div_q <= div_q + 2'h1;
      tx_req_o <= (div_q == 2'h3);
      crc_q <= !tx_crc_i ? 2'h0 : (crc_q == 2'h3) ? 2'h3 : crc_q + 2'h1;
      tx_done_o <= tx_crc_i && (crc_q == 2'h2); // The tail ends once, three cycles in.
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        step_q <= 7'h00;
        len_q <= len_i;
        abt_q <= abort_i;
        rx_open_o <= 1'b1;
      end else if (busy_o) begin
        step_q <= step_q + 7'h01;
        if (step_q[0] && (step_q[6:1] < len_q)) begin
          rx_valid_o <= 1'b1;
          rx_byte_o <= {2'h0, step_q[6:1]} ^ 8'h5A;
        end else if (step_q[0]) begin
          rx_end_o <= !abt_q;
          rx_abort_o <= abt_q;
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule : hfis_line_model
`default_nettype wire

// file: verif/tb.sv
/*
  Self-checking bench of the frame FIFO, interrupt and status block.
  Assumes the line model on the far side; clock enable runs; the bench pulses one collision.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); end end
module tb;
  // ==========================================================================
  // Stimulus, observed outputs and bookkeeping.
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic start = 1'b0;
  logic abt = 1'b0;
  logic [5:0] len = 6'h00;
  logic [7:0] rdata_o, tx_byte_o, rx_byte, v;
  logic irq_o, tx_req, tx_valid_o, tx_crc_o, tx_abort_o, tx_done, rx_valid, rx_open, rx_end, rx_abort, busy;
  logic coll = 1'b0;
  int n;
  logic crc_seen = 1'b0;
  logic abort_seen = 1'b0;
  logic [7:0] sent[$];
  logic [7:0] txq[$];
  int errors = 0;
  int compares = 0;
  integer seed = 32'h8C9A;

  always #50 sys_clk_i = ~sys_clk_i;

  hfis_top hfis_top_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .tx_req_i(tx_req),
    .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_crc_o(tx_crc_o), .tx_abort_o(tx_abort_o),
    .tx_done_i(tx_done), .collision_i(coll), .rx_valid_i(rx_valid), .rx_byte_i(rx_byte),
    .rx_open_i(rx_open), .rx_end_i(rx_end), .rx_abort_i(rx_abort));
  hfis_line_model hfis_line_model_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .start_i(start),
    .abort_i(abt), .len_i(len), .tx_crc_i(tx_crc_o), .tx_req_o(tx_req), .tx_done_o(tx_done),
    .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .rx_open_o(rx_open), .rx_end_o(rx_end),
    .rx_abort_o(rx_abort), .busy_o(busy));

  // ==========================================================================
  // Every byte the block sends on the line is captured in order; tail and abort are only flagged.
  always @(posedge sys_clk_i) begin
    if (tx_valid_o === 1'b1) txq.push_back(tx_byte_o);
    if (tx_crc_o === 1'b1) crc_seen <= 1'b1;
    if (tx_abort_o === 1'b1) abort_seen <= 1'b1;
  end

  // Visible flags are the pending ones whose mask bit is clear.
  function automatic logic [7:0] vis(input logic [7:0] p, input logic [7:0] m);
    return p & ~m;
  endfunction : vis

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken once settled in it.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o & m, e);
  endtask : rdchk

  task automatic wait_irq;
    for (int i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b1);
  endtask : wait_irq

  // The frame runs to its end before the host looks at the flags.
  task automatic rx_frame(input logic [5:0] n, input logic a);
    @(posedge sys_clk_i);
    start <= 1'b1;
    len <= n;
    abt <= a;
    @(posedge sys_clk_i);
    start <= 1'b0;
    @(posedge sys_clk_i);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge sys_clk_i);
  endtask : rx_frame

  task automatic results;
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    repeat (30000) @(posedge sys_clk_i);
    errors++;
    results();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rdchk(8'h21, 8'hFF, vis(8'h10, 8'hFC));
    rdchk(8'h22, 8'hFF, 8'hFC);
    rdchk(8'h23, 8'hFF, 8'h40);
    rdchk(8'h30, 8'hFF, 8'h00);
    `CHK(irq_o, 1'b0);
    wr(8'h22, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b1);
    rdchk(8'h21, 8'hFF, 8'h10);
    repeat (2) @(posedge sys_clk_i);
    `CHK(irq_o, 1'b0);
    // Small transmit pool and small receive block.
    wr(8'h25, 8'hA0);
    wr(8'h22, 8'hEF);
    for (int k = 0; k < 6; k++) begin
      v = $random(seed);
      wr($random(seed) & 8'h1F, v);
      sent.push_back(v);
    end
    wr(8'h24, 8'h0A);
    rdchk(8'h23, 8'h02, 8'h02);
    wait_irq();
    rdchk(8'h21, 8'hFF, 8'h10);
    `CHK(crc_seen, 1'b1);
    `CHK(txq.size(), 6);
    foreach (sent[i]) `CHK(txq[i], sent[i]);
    rdchk(8'h23, 8'h02, 8'h00);
    // A frame left open runs dry and must be aborted.
    wr(8'h22, 8'hFB);
    for (int k = 0; k < 3; k++) wr(8'h00, $random(seed));
    wr(8'h24, 8'h08);
    wait_irq();
    rdchk(8'h21, 8'hFF, 8'h04);
    `CHK(abort_seen, 1'b1);
    wr(8'h22, 8'h00);
    rdchk(8'h21, 8'h10, 8'h10);
    // One byte beyond a 16 byte pool sets the overflow status bit.
    wr(8'h24, 8'h01);
    for (int k = 0; k < 17; k++) wr(k, $random(seed));
    rdchk(8'h23, 8'h80, 8'h80);
    wr(8'h24, 8'h01);
    rdchk(8'h23, 8'h40, 8'h40);
    // A collision once a whole pool has gone out asks for a repeat.
    wr(8'h22, 8'hF7);
    for (int k = 0; k < 20; k++) wr(8'h00, k);
    n = txq.size();
    wr(8'h24, 8'h0A);
    for (int i = 0; i < 2000 && txq.size() < n + 17; i++) @(posedge sys_clk_i);
    coll <= 1'b1;
    @(posedge sys_clk_i);
    coll <= 1'b0;
    wait_irq();
    rdchk(8'h21, 8'hFF, 8'h08);
    // Receive a short frame, up to the full block length.
    wr(8'h24, 8'h80);
    wr(8'h22, 8'h7F);
    len = 6'h01 + ($random(seed) & 6'h0F);
    rx_frame(len, 1'b0);
    wait_irq();
    rdchk(8'h21, 8'hFF, 8'h80);
    rdchk(8'h23, 8'h08, 8'h08);
    rdchk(8'h26, 8'hFF, {2'h0, len});
    for (int i = 0; i < len; i++) rdchk(8'h20, 8'hFF, i[7:0] ^ 8'h5A);
    wr(8'h24, 8'h80);
    rx_frame(6'h02, 1'b1);
    rdchk(8'h23, 8'h08, 8'h00);
    // A long frame left unanswered overflows after its first block.
    wr(8'h24, 8'h40);
    wr(8'h22, 8'hDF);
    rx_frame(6'h14, 1'b0);
    wait_irq();
    rdchk(8'h21, 8'hFF, 8'h20);
    wr(8'h22, 8'h00);
    rdchk(8'h21, 8'h40, 8'h40);
    results();
  end
endmodule : tb
`default_nettype wire
